// ==== include/ers_cfg.svh ====
// Timing and encoding constants for the restart start sequencer
`ifndef ERS_CFG_SVH
`define ERS_CFG_SVH
`define ERS_CLK_HZ         20000000
`define ERS_TICK_MS        100
`define ERS_TICK_CYC       ((`ERS_CLK_HZ / 1000) * `ERS_TICK_MS)
`define ERS_TICK_W         24
`define ERS_TB_W           8
`define ERS_BYPASS_TICK    8'h01
`define ERS_THRUST_TICK    8'h04
`define ERS_GIMBAL_TICK    8'h05
`define ERS_OVERRIDE_TICK  8'h0A
`define ERS_VALVE_TIMER    8'h05
`define ERS_CHILL_EXTRA    8'h05
`define ERS_MAINSTAGE_DLY  8'h06
`endif

// ==== include/ers_pkg.sv ====
// Types for the restart start sequencer
package ers_pkg;
  typedef struct packed {
    logic startCmd;
    logic readyBypass;
    logic thrusterDisable;
    logic gimbalEnable;
    logic tcOverride;
    logic oxPressOpen;
  } ers_cmd_t;
  typedef struct packed {
    logic dischargeOpen;
    logic mainstage;
    logic mainstageSolenoid;
    logic cutoff;
  } ers_eng_t;
  typedef struct packed {
    logic tempGood;
    logic ullageLow;
    logic startTankDepress;
    logic mainstageNotOk;
  } ers_sense_t;
  typedef enum logic [3:0] {
    ERS_IDLE   = 4'b0001,
    ERS_CHILL  = 4'b0010,
    ERS_OPEN   = 4'b0100,
    ERS_MAIN   = 4'b1000
  } ers_state_t;
endpackage : ers_pkg

// ==== core/ers_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ers_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Only update once stages two and three agree
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else if (ce) begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
  assign dout = out_q;
endmodule : ers_sync

// ==== core/ers_sequencer.sv ====
// Engine restart start-phase command sequencer
//
// Notes on behaviour
// - Enabled pressurization valve opens on low ullage
// - Time zero issues engine start command
// - Ready bypass at 0.1 s, unmanned only
// - Bypass suppresses malfunction cutoff modes
// - Thruster pitch/yaw disabled at 0.4 s
// - Discharge valve opens 0.5 s if warm
// - Cold: wait 0.5 s more, open on signal
// - Gimballing enabled at 0.5 s
// - Override at 1.0 s forces valve open
// - Mainstage 0.6 s after valve open
// - Override path delays events 0.5 s
`timescale 1ns/1ps
`include "ers_cfg.svh"
module ers_sequencer #(
  parameter int TICK_CYC = `ERS_TICK_CYC
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             restartRef,
  input  wire logic             unmanned,
  input  wire logic             oxPressEnable,
  input  wire ers_pkg::ers_sense_t sense,
  output ers_pkg::ers_cmd_t     cmd,
  output ers_pkg::ers_eng_t     eng,
  output logic [`ERS_TB_W-1:0]  timeBase
);
  import ers_pkg::*;

  ers_sense_t senseSync;
  ers_sync #(.W($bits(ers_sense_t))) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .din    (sense),
    .dout   (senseSync)
  );

  // Time base
  logic [`ERS_TICK_W-1:0] div_q, div_d;
  logic [`ERS_TB_W-1:0]   tb_q, tb_d;
  logic                   run_q, run_d;
  logic                   tick;

  always_comb begin
    tick = run_q && (div_q == `ERS_TICK_W'(TICK_CYC - 1));
    div_d = div_q;
    tb_d  = tb_q;
    run_d = run_q;
    if (restartRef) begin
      div_d = '0;
      tb_d  = '0;
      run_d = 1'b1;
    end else if (run_q) begin
      div_d = tick ? '0 : div_q + `ERS_TICK_W'(1);
      if (tick && tb_q != '1) begin
        tb_d = tb_q + `ERS_TB_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_q <= '0;
      tb_q  <= '0;
      run_q <= 1'b0;
    end else if (ce) begin
      div_q <= div_d;
      tb_q  <= tb_d;
      run_q <= run_d;
    end
  end

  // Computer commands
  ers_cmd_t cmd_q, cmd_d;

  always_comb begin
    cmd_d = cmd_q;
    if (restartRef) begin
      cmd_d = '0;
    end else if (run_q) begin
      cmd_d.startCmd = 1'b1;
      if (tb_q >= `ERS_BYPASS_TICK && unmanned) begin
        cmd_d.readyBypass = 1'b1;
      end
      if (tb_q >= `ERS_THRUST_TICK) begin
        cmd_d.thrusterDisable = 1'b1;
      end
      if (tb_q >= `ERS_GIMBAL_TICK) begin
        cmd_d.gimbalEnable = 1'b1;
      end
      if (tb_q >= `ERS_OVERRIDE_TICK) begin
        cmd_d.tcOverride = 1'b1;
      end
    end
    cmd_d.oxPressOpen = oxPressEnable && senseSync.ullageLow;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmd_q <= '0;
    end else if (ce) begin
      cmd_q <= cmd_d;
    end
  end

  // Engine-side sequencer
  ers_state_t           st_q, st_d;
  logic [`ERS_TB_W-1:0] tmr_q, tmr_d;
  logic                 ovr_q, ovr_d;
  logic                 nomPoint;
  logic                 chillEnd;
  ers_eng_t             eng_q, eng_d;

  always_comb begin
    nomPoint = tick && (tmr_q == `ERS_VALVE_TIMER - `ERS_TB_W'(1));
    chillEnd = tick && (tmr_q == `ERS_CHILL_EXTRA - `ERS_TB_W'(1));
    st_d  = st_q;
    tmr_d = tmr_q;
    ovr_d = ovr_q;
    eng_d = eng_q;
    eng_d.cutoff = 1'b0;
    case (st_q)
      ERS_IDLE: begin
        if (cmd_q.startCmd) begin
          st_d  = ERS_CHILL;
          tmr_d = '0;
          ovr_d = 1'b0;
        end
      end
      ERS_CHILL: begin
        if (tick) begin
          tmr_d = tmr_q + `ERS_TB_W'(1);
        end
        if (tmr_q >= `ERS_VALVE_TIMER && senseSync.tempGood) begin
          st_d  = ERS_OPEN;
          tmr_d = '0;
        end else if (nomPoint && senseSync.tempGood) begin
          st_d  = ERS_OPEN;
          tmr_d = '0;
        end else if (tmr_q >= `ERS_VALVE_TIMER + `ERS_CHILL_EXTRA && cmd_q.tcOverride) begin
          // Override opens the valve 0.5 s late
          st_d  = ERS_OPEN;
          tmr_d = '0;
          ovr_d = 1'b1;
        end
      end
      ERS_OPEN: begin
        eng_d.dischargeOpen = 1'b1;
        if (tick) begin
          tmr_d = tmr_q + `ERS_TB_W'(1);
        end
        if (tick && tmr_q == `ERS_MAINSTAGE_DLY - `ERS_TB_W'(1)) begin
          st_d = ERS_MAIN;
        end
      end
      ERS_MAIN: begin
        eng_d.dischargeOpen     = 1'b1;
        eng_d.mainstage         = 1'b1;
        eng_d.mainstageSolenoid = 1'b1;
      end
      default: begin
        st_d = ERS_IDLE;
      end
    endcase
    if (!cmd_q.readyBypass && st_q != ERS_IDLE) begin
      // Malfunction cutoff unless bypassed
      eng_d.cutoff = senseSync.startTankDepress ||
                     (st_q == ERS_MAIN && senseSync.mainstageNotOk);
    end
    if (restartRef) begin
      st_d  = ERS_IDLE;
      tmr_d = '0;
      ovr_d = 1'b0;
      eng_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q  <= ERS_IDLE;
      tmr_q <= '0;
      ovr_q <= 1'b0;
      eng_q <= '0;
    end else if (ce) begin
      st_q  <= st_d;
      tmr_q <= tmr_d;
      ovr_q <= ovr_d;
      eng_q <= eng_d;
    end
  end

  assign cmd      = cmd_q;
  assign eng      = eng_q;
  assign timeBase = tb_q;

  // Assertions
  bypass_unmanned_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd_q.readyBypass |-> unmanned || $past(cmd_q.readyBypass))
    else $error("bypass without unmanned");
  bypass_time_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(cmd_q.readyBypass) |-> tb_q >= `ERS_BYPASS_TICK)
    else $error("bypass early");
  thrust_time_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(cmd_q.thrusterDisable) |-> tb_q == `ERS_THRUST_TICK)
    else $error("thruster disable off time");
  gimbal_time_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(cmd_q.gimbalEnable) |-> tb_q == `ERS_GIMBAL_TICK)
    else $error("gimbal off time");
  override_time_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(cmd_q.tcOverride) |-> tb_q == `ERS_OVERRIDE_TICK)
    else $error("override off time");
  valve_warm_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(eng_q.dischargeOpen) |-> $past(senseSync.tempGood) || ovr_q)
    else $error("valve opened cold");
  valve_early_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(eng_q.dischargeOpen) |-> tb_q >= `ERS_VALVE_TIMER)
    else $error("valve opened early");
  override_late_a: assert property (@(posedge mclk) disable iff (!resetn)
    ($rose(eng_q.dischargeOpen) && ovr_q) |-> tb_q >= `ERS_VALVE_TIMER + `ERS_CHILL_EXTRA)
    else $error("override open too soon");
  mainstage_order_a: assert property (@(posedge mclk) disable iff (!resetn)
    eng_q.mainstage |-> eng_q.dischargeOpen && eng_q.mainstageSolenoid)
    else $error("mainstage without valve");
  bypass_cutoff_a: assert property (@(posedge mclk) disable iff (!resetn || restartRef)
    $past(cmd_q.readyBypass) |-> !eng_q.cutoff)
    else $error("cutoff while bypassed");
  press_valve_a: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && oxPressEnable && senseSync.ullageLow) |=> cmd_q.oxPressOpen)
    else $error("press valve not opened");
endmodule : ers_sequencer

// ==== bench/ers_engine_model.sv ====
// Engine-side sensor and tank model
`timescale 1ns/1ps
module ers_engine_model (
  input  wire logic              mclk,
  input  wire logic              tgOn,
  input  wire logic              depOn,
  input  wire logic              notOkOn,
  input  wire logic              ullDrop,
  input  wire ers_pkg::ers_cmd_t cmd,
  output ers_pkg::ers_sense_t    sense
);
  import ers_pkg::*;
  int   fill = 0;
  logic low  = 1'b0;
  // Ullage recovers only after 20 cycles of open valve
  always @(posedge mclk) begin
    if (ullDrop) begin
      low  <= #1 1'b1;
      fill <= 0;
    end else if (low && cmd.oxPressOpen) begin
      fill <= fill + 1;
      if (fill >= 19) low <= #1 1'b0;
    end
  end
  assign sense = '{tempGood: tgOn, ullageLow: low, startTankDepress: depOn, mainstageNotOk: notOkOn};
endmodule : ers_engine_model

// ==== bench/testbench.sv ====
// Self-checking bench for the restart start sequencer
`timescale 1ns/1ps
module testbench;
  import ers_pkg::*;
  localparam int T = 10;
  logic mclk = 0, resetn = 0, ce = 1, restartRef = 0, unmanned = 0, oxPressEnable = 0;
  logic tgOn = 0, depOn = 0, notOkOn = 0, ullDrop = 0;
  ers_sense_t sense;
  ers_cmd_t cmd;
  ers_eng_t eng;
  logic [7:0] timeBase;
  logic [6:0] sig, prev = '0;
  int n_fail = 0, check_count = 0, cyc = 0;
  int rise[7];
  ers_sequencer #(.TICK_CYC(T)) u_dut (.mclk(mclk), .resetn(resetn), .ce(ce), .restartRef(restartRef),
    .unmanned(unmanned), .oxPressEnable(oxPressEnable), .sense(sense), .cmd(cmd), .eng(eng), .timeBase(timeBase));
  ers_engine_model u_eng (.mclk(mclk), .tgOn(tgOn), .depOn(depOn), .notOkOn(notOkOn), .ullDrop(ullDrop),
    .cmd(cmd), .sense(sense));
  initial begin
    forever #25 mclk = ~mclk;
  end
  assign sig = {cmd.startCmd, cmd.readyBypass, cmd.thrusterDisable, cmd.gimbalEnable, cmd.tcOverride,
    eng.dischargeOpen, eng.mainstage};
  // First rising edge of each event, counted from the restart pulse
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    prev <= sig;
    for (int i = 0; i < 7; i++) begin
      if (sig[6-i] && !prev[6-i] && rise[i] < 0) rise[i] = cyc;
    end
  end
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic win(input int i, input int tick);
    chk(rise[i] >= tick * T && rise[i] <= tick * T + T + 8, $sformatf("event %0d late or early", i));
  endtask : win
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic run(input logic um, input int tg);
    int v;
    unmanned = um;
    tgOn = (tg == 0);
    restartRef = 1;
    cyc = 0;
    foreach (rise[i]) rise[i] = -1;
    tick(1);
    restartRef = 0;
    for (int c = 1; c < 20 * T; c++) begin
      if (c == tg * T) tgOn = 1;
      tick(1);
    end
    v = tg <= 5 ? 5 : (tg < 10 ? tg : 10);
    win(0, 0);
    if (um) win(1, 1);
    else chk(rise[1] < 0, "bypass while manned");
    win(2, 4);
    win(3, 5);
    win(5, v);
    win(6, v + 6);
    if (tg >= 10) win(4, 10);
    chk(eng.mainstageSolenoid === 1'b1, "solenoid off");
    // Restart edge plus 20*T-1 stepped edges, one count per T cycles
    chk(timeBase === 8'((20 * T - 2) / T), "time base count");
  endtask : run
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #(5000 * T * 50);
    chk(1'b0, "watchdog expired");
    test_done;
  end
  initial begin
    void'($urandom(61189));
    tick(10);
    resetn = 1;
    run(1, 0);
    run(1, 6 + $urandom % 4);
    run(1, 30);
    depOn = 1;
    tick(8);
    chk(eng.cutoff === 1'b0, "cutoff under bypass");
    depOn = 0;
    run(0, 3);
    notOkOn = 1;
    tick(8);
    chk(eng.cutoff === 1'b1, "no cutoff");
    notOkOn = 0;
    // Clock enable low must freeze the time base over several ticks
    begin
      logic [7:0] tbHold;
      tbHold = timeBase;
      ce = 0;
      tick(3 * T);
      chk(timeBase === tbHold, "time base moved with enable low");
      ce = 1;
    end
    for (int e = 0; e < 2; e++) begin
      oxPressEnable = e;
      ullDrop = 1;
      tick(1);
      ullDrop = 0;
      tick(8);
      chk(cmd.oxPressOpen === e[0], "press valve");
      if (e == 1) begin
        tick(40);
        chk(cmd.oxPressOpen === 1'b0, "press valve stuck");
      end
    end
    test_done;
  end
endmodule : testbench
